// [qspio_pkg.sv]
// constants, types and lane decoding shared by the pin-level flash link
package qspio_pkg;

  // ****************************************
  // widths and depths
  // ****************************************
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int LINE_N = 4;
  localparam int SYNC_N = 2;

  typedef logic [BYTE_W-1:0] qspio_byte_t;
  typedef logic [2:0] qspio_cnt_t;

  // ****************************************
  // lane modes and reset values
  // ****************************************
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h1;
  localparam logic [1:0] MODE_QUAD = 2'h2;
  localparam qspio_cnt_t CNT_ZERO = 3'h0;
  localparam qspio_byte_t BYTE_ZERO = 8'h00;
  // filler launched when no read byte is waiting
  localparam qspio_byte_t TX_IDLE = 8'hff;

  // bits moved per serial clock for a lane mode
  function automatic qspio_cnt_t lanes_of(input logic [1:0] mode);
    qspio_cnt_t n;
    n = 3'h1;
    case (mode)
      MODE_DUAL: n = 3'h2;
      MODE_QUAD: n = 3'h4;
      default: n = 3'h1;
    endcase
    return n;
  endfunction

  // true when the device drives line idx while sending in this mode
  function automatic logic line_drives(input logic [1:0] mode, input int idx);
    logic d;
    d = 1'b0;
    if (mode == MODE_DUAL)
    begin
      d = (idx < 2);
    end
    else if (mode == MODE_QUAD)
    begin
      d = 1'b1;
    end
    else
    begin
      d = (idx == 1);
    end
    return d;
  endfunction

endpackage

// [qspio_stream_if.sv]
// valid/ready byte stream carrier between the link top and its fifo
`timescale 1ns/1ps
interface qspio_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [qspio_fifo.sv]
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module qspio_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // fill and drain sides
  qspio_stream_if.snk fill,
  qspio_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
              (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire do_wr = fill.valid && !full;
  wire do_rd = drain.ready && !empty;

  assign fill.ready = !full;
  assign drain.valid = !empty;
  assign drain.data = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_rd)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // storage carries no reset; only slots behind the pointers are read
  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem_r[wr_ptr_r[AW-1:0]] <= fill.data;
  end
endmodule

// [qspio_link.sv]
// device-side pin logic of a quad-capable serial configuration flash
`timescale 1ns/1ps
// Functional notes
// - The link has four data lines, a serial clock input and an active-low select.
// - In single-line mode write data arrives on io_line_0, captured on the rising clock.
// - In four-line mode io_line_0 is sampled on rising edges for writes and driven on falling edges for reads.
// - In single-line mode read data leaves on io_line_1, changing on falling edges.
// - Dual fast writes bring data on io_line_0 and io_line_1, quad writes on all four lines, latched on rising edges.
// - Dual fast reads drive data on io_line_0 and io_line_1, quad reads on all four lines, shifted on falling edges.
// - With chip_select_n high the device is deselected and tri-stated; after reset the select must be seen high before a fall starts a frame.
module qspio_link (
  // core clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // flash pins
  input wire logic serial_clock_in,
  input wire logic chip_select_n,
  input wire logic [qspio_pkg::LINE_N-1:0] io_line_in,
  output logic [qspio_pkg::LINE_N-1:0] io_line_out,
  output logic [qspio_pkg::LINE_N-1:0] io_line_oe,
  // operation setup
  input wire logic [1:0] lane_mode,
  input wire logic send_dir,
  // read data to send
  input wire logic [qspio_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // write data received
  output logic [qspio_pkg::BYTE_W-1:0] rx_data,
  output logic rx_valid,
  // status
  output logic frame_active,
  output logic armed
);

  // ****************************************
  // core domain: setup, select sense, reset to link
  // ****************************************
  logic [qspio_pkg::SYNC_N-1:0] cs_sync_r;
  logic armed_r;
  logic lrst_r;
  logic [1:0] mode_r;
  logic dir_r;

  always_ff @(posedge core_clk)
  begin
    lrst_r <= srst;
    cs_sync_r <= {cs_sync_r[0], chip_select_n};
    if (srst)
    begin
      armed_r <= 1'b0;
      mode_r <= qspio_pkg::MODE_SINGLE;
      dir_r <= 1'b0;
    end
    else
    begin
      // select seen high first, so the next fall starts a real frame
      if (cs_sync_r[1])
        armed_r <= 1'b1;
      mode_r <= lane_mode;
      dir_r <= send_dir;
    end
  end

  assign frame_active = !cs_sync_r[1] && armed_r;
  assign armed = armed_r;

  // ****************************************
  // link domain: setup crossing
  // ****************************************
  // setup is quasi-static: it must settle before a frame begins
  logic [1:0] mode_s1_r;
  logic [1:0] mode_s2_r;
  logic dir_s1_r;
  logic dir_s2_r;
  logic arm_s1_r;
  logic arm_s2_r;

  always_ff @(posedge serial_clock_in or posedge lrst_r)
  begin
    if (lrst_r)
    begin
      mode_s1_r <= qspio_pkg::MODE_SINGLE;
      mode_s2_r <= qspio_pkg::MODE_SINGLE;
      {dir_s1_r, dir_s2_r, arm_s1_r, arm_s2_r} <= 4'h0;
    end
    else
    begin
      mode_s1_r <= mode_r;
      mode_s2_r <= mode_s1_r;
      dir_s1_r <= dir_r;
      dir_s2_r <= dir_s1_r;
      arm_s1_r <= armed_r;
      arm_s2_r <= arm_s1_r;
    end
  end

  wire lanes_en = !chip_select_n && arm_s2_r;
  wire link_idle = chip_select_n || lrst_r;
  wire [2:0] lanes = qspio_pkg::lanes_of(mode_s2_r);

  // ****************************************
  // link domain: capture on rising edge
  // ****************************************
  logic [qspio_pkg::BYTE_W-1:0] rx_sh_r;
  qspio_pkg::qspio_cnt_t rx_cnt_r;
  logic [qspio_pkg::BYTE_W-1:0] rx_hold_r;
  logic rx_tgl_r;
  logic [qspio_pkg::BYTE_W-1:0] rx_nxt;

  // lanes shift in msb first; the highest line carries the oldest bit
  assign rx_nxt = (mode_s2_r == qspio_pkg::MODE_QUAD) ?
                    {rx_sh_r[3:0], io_line_in[3:0]} :
                  (mode_s2_r == qspio_pkg::MODE_DUAL) ?
                    {rx_sh_r[5:0], io_line_in[1:0]} :
                    {rx_sh_r[6:0], io_line_in[0]};
  wire rx_take = lanes_en && !dir_s2_r;
  wire [2:0] rx_cnt_nxt = rx_cnt_r + lanes;
  wire rx_done = rx_take && (rx_cnt_nxt == qspio_pkg::CNT_ZERO);

  // partial bytes are dropped when the select rises
  always_ff @(posedge serial_clock_in or posedge link_idle)
  begin
    if (link_idle)
    begin
      rx_sh_r <= qspio_pkg::BYTE_ZERO;
      rx_cnt_r <= qspio_pkg::CNT_ZERO;
    end
    else if (rx_take)
    begin
      rx_sh_r <= rx_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  always_ff @(posedge serial_clock_in or posedge lrst_r)
  begin
    if (lrst_r)
    begin
      rx_hold_r <= qspio_pkg::BYTE_ZERO;
      rx_tgl_r <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_hold_r <= rx_nxt;
      rx_tgl_r <= !rx_tgl_r;
    end
  end

  // ****************************************
  // link domain: launch on falling edge
  // ****************************************
  logic [qspio_pkg::BYTE_W-1:0] tx_sh_r;
  qspio_pkg::qspio_cnt_t tx_cnt_r;
  logic tx_ack_r;
  logic [qspio_pkg::SYNC_N-1:0] req_sync_r;
  logic tx_req_r;
  logic [qspio_pkg::BYTE_W-1:0] tx_hold_r;

  wire tx_send = lanes_en && dir_s2_r;
  wire tx_load = tx_send && (tx_cnt_r == qspio_pkg::CNT_ZERO);
  wire tx_have = (req_sync_r[1] != tx_ack_r);

  always_ff @(negedge serial_clock_in or posedge lrst_r)
  begin
    if (lrst_r)
    begin
      req_sync_r <= '0;
      tx_ack_r <= 1'b0;
    end
    else
    begin
      req_sync_r <= {req_sync_r[0], tx_req_r};
      if (tx_load && tx_have)
        tx_ack_r <= !tx_ack_r;
    end
  end

  // underrun sends the idle filler rather than stale bits
  always_ff @(negedge serial_clock_in or posedge link_idle)
  begin
    if (link_idle)
    begin
      tx_sh_r <= qspio_pkg::TX_IDLE;
      tx_cnt_r <= qspio_pkg::CNT_ZERO;
    end
    else if (tx_send)
    begin
      if (tx_load)
        tx_sh_r <= tx_have ? tx_hold_r : qspio_pkg::TX_IDLE;
      else
        tx_sh_r <= tx_sh_r << lanes;
      tx_cnt_r <= tx_cnt_r + lanes;
    end
  end

  // ****************************************
  // pins: drive only the lanes of the mode
  // ****************************************
  wire drive = tx_send;
  genvar gi;
  generate
    for (gi = 0; gi < qspio_pkg::LINE_N; gi++)
    begin : g_line
      assign io_line_oe[gi] = drive &&
        qspio_pkg::line_drives(mode_s2_r, gi);
    end
  endgenerate

  assign io_line_out = (mode_s2_r == qspio_pkg::MODE_QUAD) ? tx_sh_r[7:4] :
                       (mode_s2_r == qspio_pkg::MODE_DUAL) ?
                         {2'h0, tx_sh_r[7:6]} :
                         {2'h0, tx_sh_r[7], 1'b0};

  // ****************************************
  // core domain: read bytes from fifo to holding register
  // ****************************************
  qspio_stream_if #(.W(qspio_pkg::BYTE_W)) fill_if ();
  qspio_stream_if #(.W(qspio_pkg::BYTE_W)) drain_if ();
  logic [qspio_pkg::SYNC_N-1:0] ack_sync_r;

  assign fill_if.valid = tx_valid;
  assign fill_if.data = tx_data;
  assign tx_ready = fill_if.ready;
  // holding register empties only when the link has acked it
  assign drain_if.ready = (tx_req_r == ack_sync_r[1]);

  qspio_fifo #(
    .W(qspio_pkg::BYTE_W),
    .DEPTH(qspio_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .srst(srst),
    .fill(fill_if),
    .drain(drain_if)
  );

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ack_sync_r <= '0;
      tx_req_r <= 1'b0;
      tx_hold_r <= qspio_pkg::BYTE_ZERO;
    end
    else
    begin
      ack_sync_r <= {ack_sync_r[0], tx_ack_r};
      if (drain_if.ready && drain_if.valid)
      begin
        tx_hold_r <= drain_if.data;
        tx_req_r <= !tx_req_r;
      end
    end
  end

  // ****************************************
  // core domain: received bytes out
  // ****************************************
  logic [qspio_pkg::SYNC_N-1:0] rx_sync_r;
  logic rx_seen_r;
  logic [qspio_pkg::BYTE_W-1:0] rx_data_r;
  logic rx_valid_r;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rx_sync_r <= '0;
      rx_seen_r <= 1'b0;
      rx_data_r <= qspio_pkg::BYTE_ZERO;
      rx_valid_r <= 1'b0;
    end
    else
    begin
      rx_sync_r <= {rx_sync_r[0], rx_tgl_r};
      rx_seen_r <= rx_sync_r[1];
      rx_valid_r <= (rx_sync_r[1] != rx_seen_r);
      if (rx_sync_r[1] != rx_seen_r)
        rx_data_r <= rx_hold_r;
    end
  end

  assign rx_data = rx_data_r;
  assign rx_valid = rx_valid_r;

endmodule

// [qspio_link_asserts.sv]
// pin-level assertions on the flash link top
`timescale 1ns/1ps
module qspio_link_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // pins and setup
  input wire logic chip_select_n,
  input wire logic [3:0] io_line_oe,
  input wire logic [1:0] lane_mode,
  input wire logic send_dir,
  // results and status
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic frame_active,
  input wire logic armed
);
  // ****
  // checks
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  desel_tri_a: assert property (chip_select_n |-> io_line_oe == 4'h0)
    else $error("lines driven while deselected");
  unarmed_a: assert property (!armed
    |-> io_line_oe == 4'h0 && !frame_active)
    else $error("activity before arming");
  sel_track_a: assert property ($fell(chip_select_n) && armed
    |-> ##[2:3] frame_active)
    else $error("frame not seen after select fell");
  armed_hold_a: assert property (armed |=> armed)
    else $error("arming lost");
  recv_release_a: assert property (frame_active && !send_dir
    |-> io_line_oe == 4'h0)
    else $error("line driven while receiving");
  single_oe_a: assert property (frame_active && send_dir && !chip_select_n
    && lane_mode == 2'h0 |-> io_line_oe == 4'h2)
    else $error("single send enables wrong");
  dual_oe_a: assert property (frame_active && send_dir && !chip_select_n
    && lane_mode == 2'h1 |-> io_line_oe == 4'h3)
    else $error("dual send enables wrong");
  quad_oe_a: assert property (frame_active && send_dir && !chip_select_n
    && lane_mode == 2'h2 |-> io_line_oe == 4'hf)
    else $error("quad send enables wrong");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("receive pulse too long");
  rx_hold_a: assert property ($changed(rx_data) |-> rx_valid)
    else $error("received byte changed without pulse");
endmodule

// [qspio_host.sv]
// host model: serial clock, select and data lines
`timescale 1ns/1ps
module qspio_host (
  // device drive
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe,
  // host pins
  output logic sck,
  output logic cs_n,
  output logic [3:0] host_oe,
  output wire logic [3:0] lvl
);
  logic [3:0] hd;
  logic tog;
  byte unsigned rxq[$];
  // released lines toggle so a stale value never passes
  assign lvl = (dev_oe & dev_out) | (~dev_oe & host_oe & hd)
    | (~dev_oe & ~host_oe & {4{tog}});
  initial
  begin
    sck = 0;
    cs_n = 1;
    host_oe = 0;
    hd = 0;
    tog = 0;
    forever #16 tog = ~tog;
  end
  // ****
  // one frame
  // ****
  task frame(input int n, input logic dir, input int nb,
    input byte unsigned txq[$]);
    int b, k;
    logic [7:0] x, sh;
    logic [3:0] msk, v;
    msk = n == 4 ? 4'hf : n == 2 ? 4'h3 : 4'h1;
    // setup crosses on the serial clock, so clock with select high
    repeat (3)
    begin
      #32 sck = 1;
      #32 sck = 0;
    end
    #100 cs_n = 0;
    host_oe = dir ? 4'h0 : msk;
    if (dir)
    begin
      #32 sck = 1;
      #32 sck = 0;
    end
    for (b = 0; b < nb; b++)
    begin
      x = dir ? 8'h00 : txq[b];
      for (k = 0; k < 8 / n; k++)
      begin
        hd = 4'(x >> (8 - n * (k + 1))) & msk;
        #32 sck = 1;
        v = n == 1 ? {3'h0, lvl[1]} : lvl & msk;
        sh = 8'(sh << n) | {4'h0, v};
        #32 sck = 0;
      end
      if (dir)
        rxq.push_back(sh);
      else
        #200;
    end
    #40 cs_n = 1;
    host_oe = 0;
  endtask
endmodule

// [qspio_link_bench.sv]
// self-checking bench for the flash pin link
`timescale 1ns/1ps
module qspio_link_bench;
  logic core_clk, srst, tx_valid, send_dir, rx_valid, tx_ready, rd;
  logic frame_active, armed, sck, cs_n;
  logic [1:0] lane_mode;
  logic [7:0] tx_data, rx_data;
  logic [3:0] dout, doe, hoe;
  wire [3:0] lvl;
  int mismatches, num_checks, md;
  byte unsigned expq[$], rxexp[$], q[$];
  qspio_host i_host (.dev_out(dout), .dev_oe(doe), .sck(sck),
    .cs_n(cs_n), .host_oe(hoe), .lvl(lvl));
  qspio_link i_dut (.core_clk(core_clk), .srst(srst),
    .serial_clock_in(sck), .chip_select_n(cs_n), .io_line_in(lvl),
    .io_line_out(dout), .io_line_oe(doe), .lane_mode(lane_mode),
    .send_dir(send_dir), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .frame_active(frame_active), .armed(armed));
  initial
  begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  // ****
  // helpers
  // ****
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task push(input int tries);
    // start just after an edge so each try spans exactly one edge
    @(posedge core_clk);
    #1;
    repeat (tries)
    begin
      tx_data = 8'($urandom);
      tx_valid = 1;
      #10 rd = tx_ready;
      @(posedge core_clk);
      if (rd)
        expq.push_back(tx_data);
      #1;
    end
    tx_valid = 0;
  endtask
  task send(input int n);
    i_host.frame(n, 1, expq.size() + 1, q);
    while (expq.size())
      chk("tx_byte", i_host.rxq.pop_front(), expq.pop_front());
    // held bytes go first; the drained fifo then launches the filler
    chk("filler", i_host.rxq.pop_front(), 8'hff);
  endtask
  // sample registered outputs away from the edge that launches them
  always @(negedge core_clk)
    if (rx_valid === 1'b1)
      chk("rx_data", rx_data, rxexp.size() ? rxexp.pop_front() : 8'h00);
  always @(posedge sck)
    chk("overlap", {4'h0, doe & hoe}, 8'h00);
  initial
  begin
    #500000;
    mismatches++;
    tally_and_finish();
  end
  // ****
  // tests
  // ****
  initial
  begin
    srst = 1;
    tx_valid = 0;
    tx_data = 0;
    lane_mode = 0;
    send_dir = 0;
    void'($urandom(83));
    repeat (6) @(posedge core_clk);
    #1 srst = 0;
    repeat (5) @(posedge core_clk);
    chk("armed", {7'h0, armed}, 8'h01);
    for (md = 0; md < 4; md++)
    begin
      #1 lane_mode = 2'(md);
      q = '{8'($urandom), 8'($urandom), 8'($urandom)};
      rxexp = q;
      // code 3 falls back to single-line
      i_host.frame(md == 3 ? 1 : 1 << md, 0, 3, q);
      repeat (10) @(posedge core_clk);
      chk("rx_left", 8'(rxexp.size()), 8'h00);
      $display("receive mode %0d done", md);
    end
    #1 lane_mode = 0;
    send_dir = 1;
    push(40);
    chk("tx_full", {7'h0, tx_ready}, 8'h00);
    chk("fill", {7'h0, expq.size() >= 32}, 8'h01);
    send(1);
    chk("tx_empty", {7'h0, tx_ready}, 8'h01);
    $display("fill and drain done");
    for (md = 1; md < 3; md++)
    begin
      @(posedge core_clk);
      #1 lane_mode = 2'(md);
      push(1);
      repeat (4) @(posedge core_clk);
      send(1 << md);
      $display("send mode %0d done", md);
    end
    tally_and_finish();
  end
endmodule
bind qspio_link qspio_link_asserts i_chk (.core_clk(core_clk), .srst(srst),
  .chip_select_n(chip_select_n), .io_line_oe(io_line_oe),
  .lane_mode(lane_mode), .send_dir(send_dir), .rx_data(rx_data),
  .rx_valid(rx_valid), .frame_active(frame_active), .armed(armed));
